//--- hw/mpbc_bus_ctrl.sv
/*
  Memory and peripheral bus control: address, data, transceiver strobes,
  chip selects, wait or acknowledge, external master grant, reset pin and
  clock output. Assumes core requests and pins synchronous to i_sys_clk;
  two-way pins are resolved outside from the output enables.
*/
// What this block does
// - Drive a 26-bit address bus for memory and peripheral accesses.
// - In small-outline DIMM mode, address bits 20:17 carry data masks.
// - Move data over a 32-bit two-way data bus.
// - Transceiver direction low during reads, high during writes.
// - Transceiver enable 0 low during external device reads.
// - Transceiver enable 1 low during SDRAM reads only.
// - Drive grant low once the bus is given to the external master.
// - In wait mode, a low wait input lengthens the bus cycle.
// - In acknowledge mode, a low input completes the access.
// - Six low chip selects; only the addressed device's bit asserts.
// - Chip selects 4 and 5 share general-purpose pins 16 and 17.
// - Address bits 22 to 25 share general-purpose pins 27 to 30.
// - Drive the open-drain reset pin low during reset, then release.
// - Cold reset initialises state and loads the boot configuration.
// - Core clock runs two, three or four times the input clock.
// - Output a copy of the input clock; SDRAM runs on it.
// - Shared pins leave reset as general-purpose I/O unless boot says.
`timescale 1ns/1ps
`default_nettype none

module mpbc_bus_ctrl #(
  parameter int RST_CYC = mpbc_pkg::RST_DRIVE_CYC
) (
  // Clock and cold reset
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_nrst,
  // Core request port
  input  wire logic                         i_req_valid,
  output logic                              o_req_ready,
  input  wire logic                         i_req_write,
  input  wire logic                         i_req_sdram,
  input  wire logic [mpbc_pkg::CS_IDX_W-1:0] i_req_cs,
  input  wire logic [mpbc_pkg::ADDR_W-1:0]  i_req_addr,
  input  wire logic [mpbc_pkg::DATA_W-1:0]  i_req_wdata,
  input  wire logic [mpbc_pkg::MASK_W-1:0]  i_req_mask,
  output logic                              o_rsp_valid,
  output logic [mpbc_pkg::DATA_W-1:0]       o_rsp_rdata,
  // Configuration
  input  wire logic                         i_cfg_ack_mode,
  input  wire logic                         i_cfg_sodimm,
  input  wire logic [mpbc_pkg::WAIT_W-1:0]  i_cfg_wait_cyc,
  // Boot straps, caught once after cold reset
  input  wire logic                         i_boot_addr_hi,
  input  wire logic                         i_boot_cs_hi,
  input  wire logic [1:0]                   i_boot_mult,
  output logic [2:0]                        o_core_mult,
  // Clock output
  output logic                              o_sys_clk_out,
  // Address and data pins
  output logic [mpbc_pkg::ADDR_PIN_W-1:0]   o_mem_addr,
  output logic                              o_mem_addr_oe,
  input  wire logic [mpbc_pkg::DATA_W-1:0]  i_mem_data,
  output logic [mpbc_pkg::DATA_W-1:0]       o_mem_data,
  output logic                              o_mem_data_oe,
  // Strobes
  output logic                              o_xcvr_dir_n,
  output logic [1:0]                        o_xcvr_oe_n,
  output logic [mpbc_pkg::CS_PIN_N-1:0]     o_dev_sel_n,
  output logic                              o_ctl_oe,
  input  wire logic                         i_wait_or_ack_n,
  // External master
  input  wire logic                         i_ext_bus_req_n,
  output logic                              o_ext_bus_gnt_n,
  // Warm reset pin, open drain
  input  wire logic                         i_warm_rst_io_n,
  output logic                              o_warm_rst_io_n_oe,
  output logic                              o_warm_rst_req,
  // Shared general-purpose pins
  input  wire logic [mpbc_pkg::SHARE_N-1:0] i_gp_io,
  output logic [mpbc_pkg::SHARE_N-1:0]      o_gp_io,
  output logic [mpbc_pkg::SHARE_N-1:0]      o_gp_io_oe,
  input  wire logic [mpbc_pkg::SHARE_N-1:0] i_gpio_out,
  input  wire logic [mpbc_pkg::SHARE_N-1:0] i_gpio_oe,
  output logic [mpbc_pkg::SHARE_N-1:0]      o_gpio_in
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  mpbc_pkg::mpbc_state_t                 state_r, state_nxt;
  logic [mpbc_pkg::ADDR_W-1:0]           addr_r;
  logic [mpbc_pkg::DATA_W-1:0]           wdata_r, rdata_r;
  logic [mpbc_pkg::MASK_W-1:0]           mask_r;
  logic [mpbc_pkg::CS_N-1:0]             cs_n_r, cs_n_nxt;
  logic [1:0]                            boe_n_r, boe_n_nxt;
  logic                                  dir_n_r, dir_n_nxt;
  logic                                  wr_r, ctl_oe_r, gnt_n_r;
  logic                                  rsp_valid_r;
  logic [mpbc_pkg::WAIT_W-1:0]           cnt_r;
  logic [mpbc_pkg::RST_CNT_W-1:0]        rst_cnt_r;
  logic                                  rst_drv_r, pin_prev_r, warm_req_r;
  logic                                  boot_done_r, boot_addr_r;
  logic                                  boot_cs_r;
  logic [2:0]                            mult_r;

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  // Request taken only while the bus is ours, the reset pin is quiet and
  // the boot straps are in; an external master wins a tie in idle.
  logic in_idle, in_acc, in_grant, take, acc_done, wait_met;
  logic mult_x3, mult_x4;
  logic [mpbc_pkg::CS_N-1:0] cs_dec;
  logic [mpbc_pkg::ADDR_PIN_W-1:0] addr_pins;

  assign in_idle   = (state_r == mpbc_pkg::ST_IDLE);
  assign in_acc    = (state_r == mpbc_pkg::ST_ACC);
  assign in_grant  = (state_r == mpbc_pkg::ST_GRANT);
  assign o_req_ready = in_idle && i_ext_bus_req_n && !rst_drv_r
                       && boot_done_r;
  assign take      = o_req_ready && i_req_valid;
  assign wait_met  = (cnt_r >= i_cfg_wait_cyc);
  // Wait mode: the low input stretches the cycle past the base count.
  // Acknowledge mode: the cycle ends on the first low input. There is no
  // timeout, so a device that never acknowledges holds the bus.
  assign acc_done  = i_cfg_ack_mode ? !i_wait_or_ack_n
                                    : (wait_met && i_wait_or_ack_n);

  // Chip select decode; SDRAM cycles and unused codes select nothing.
  assign cs_dec = (!i_req_sdram && (i_req_cs < 3'h6))
                  ? ~(6'h01 << i_req_cs) : 6'h3F;

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      mpbc_pkg::ST_IDLE: begin
        if (!i_ext_bus_req_n && boot_done_r) begin
          state_nxt = mpbc_pkg::ST_GRANT;
        end else if (take) begin
          state_nxt = mpbc_pkg::ST_ACC;
        end
      end
      mpbc_pkg::ST_ACC: begin
        if (acc_done) begin
          state_nxt = mpbc_pkg::ST_END;
        end
      end
      mpbc_pkg::ST_END: begin
        state_nxt = mpbc_pkg::ST_IDLE;
      end
      mpbc_pkg::ST_GRANT: begin
        if (i_ext_bus_req_n) begin
          state_nxt = mpbc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = mpbc_pkg::ST_IDLE;
      end
    endcase
  end

  // Strobe levels for the next cycle: asserted only through an access.
  assign dir_n_nxt = take ? i_req_write
                   : (in_acc && !acc_done) ? dir_n_r : 1'b1;
  assign boe_n_nxt = take ? {!(!i_req_write && i_req_sdram),
                             !(!i_req_write && !i_req_sdram)}
                   : (in_acc && !acc_done) ? boe_n_r : 2'h3;
  assign cs_n_nxt  = take ? cs_dec
                   : (in_acc && !acc_done) ? cs_n_r : 6'h3F;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= mpbc_pkg::ST_IDLE;
      dir_n_r <= 1'b1;
      boe_n_r <= 2'h3;
      cs_n_r  <= 6'h3F;
    end else begin
      state_r <= state_nxt;
      dir_n_r <= dir_n_nxt;
      boe_n_r <= boe_n_nxt;
      cs_n_r  <= cs_n_nxt;
    end
  end

  // Drive enable and grant: the bus floats for the whole grant.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_oe_r <= 1'b0;
      gnt_n_r  <= 1'b1;
    end else begin
      ctl_oe_r <= boot_done_r && (state_nxt != mpbc_pkg::ST_GRANT);
      gnt_n_r  <= (state_nxt != mpbc_pkg::ST_GRANT);
    end
  end

  // Captured request; held steady for the whole access.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_r  <= 26'h000_0000;
      wdata_r <= 32'h0000_0000;
      mask_r  <= 4'h0;
      wr_r    <= 1'b0;
    end else if (take) begin
      addr_r  <= i_req_addr;
      wdata_r <= i_req_wdata;
      mask_r  <= i_req_mask;
      wr_r    <= i_req_write;
    end
  end

  // Cycle counter and read capture on the completing edge.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r       <= 4'h0;
      rdata_r     <= 32'h0000_0000;
      rsp_valid_r <= 1'b0;
    end else begin
      cnt_r       <= (in_acc && !wait_met) ? cnt_r + 4'h1
                   : (in_acc ? cnt_r : 4'h0);
      rsp_valid_r <= in_acc && acc_done;
      if (in_acc && acc_done && !wr_r) begin
        rdata_r <= i_mem_data;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Reset pin and boot straps
  // ---------------------------------------------------------------------
  // The pin is driven low from cold reset for a fixed time, and again after
  // an outside warm reset so every party sees one clean pulse. Only a fall
  // while we are not driving counts, so our own pulse never re-triggers.
  logic ext_fall;
  assign ext_fall = pin_prev_r && !i_warm_rst_io_n && !rst_drv_r;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_drv_r  <= 1'b1;
      rst_cnt_r  <= 8'h00;
      pin_prev_r <= 1'b1;
      warm_req_r <= 1'b0;
    end else begin
      pin_prev_r <= i_warm_rst_io_n;
      warm_req_r <= ext_fall;
      if (ext_fall) begin
        rst_drv_r <= 1'b1;
        rst_cnt_r <= 8'h00;
      end else if (rst_drv_r) begin
        rst_cnt_r <= rst_cnt_r + 8'h01;
        if (rst_cnt_r == 8'(RST_CYC - 1)) begin
          rst_drv_r <= 1'b0;
        end
      end
    end
  end

  // Straps are taken on the first edge after cold reset, never from the
  // reset branch, so the flops only ever load constants asynchronously.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      boot_done_r <= 1'b0;
      boot_addr_r <= 1'b0;
      boot_cs_r   <= 1'b0;
      mult_r      <= mpbc_pkg::MULT_X2;
    end else if (!boot_done_r) begin
      boot_done_r <= 1'b1;
      boot_addr_r <= i_boot_addr_hi;
      boot_cs_r   <= i_boot_cs_hi;
      mult_r      <= mult_x4 ? mpbc_pkg::MULT_X4
                   : (mult_x3 ? mpbc_pkg::MULT_X3
                              : mpbc_pkg::MULT_X2);
    end
  end
  // An unused strap code falls back to the slowest core multiple.
  assign mult_x3 = (i_boot_mult == mpbc_pkg::BOOT_MULT_X3);
  assign mult_x4 = (i_boot_mult == mpbc_pkg::BOOT_MULT_X4);

  // ---------------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------------
  // Mask enables replace address bits 20:17 only in DIMM mode.
  assign addr_pins = i_cfg_sodimm
    ? {addr_r[21], mask_r, addr_r[16:0]}
    : addr_r[mpbc_pkg::ADDR_PIN_W-1:0];

  assign o_mem_addr         = addr_pins;
  assign o_mem_addr_oe      = ctl_oe_r;
  assign o_mem_data         = wdata_r;
  assign o_mem_data_oe      = ctl_oe_r && in_acc && wr_r;
  assign o_xcvr_dir_n       = dir_n_r;
  assign o_xcvr_oe_n        = boe_n_r;
  assign o_dev_sel_n        = cs_n_r[mpbc_pkg::CS_PIN_N-1:0];
  assign o_ctl_oe           = ctl_oe_r;
  assign o_ext_bus_gnt_n    = gnt_n_r;
  assign o_rsp_valid        = rsp_valid_r;
  assign o_rsp_rdata        = rdata_r;
  assign o_warm_rst_io_n_oe = rst_drv_r;
  assign o_warm_rst_req     = warm_req_r;
  assign o_core_mult        = mult_r;
  // The clock pad buffer supplies the delay; SDRAM cycles run on this
  // same clock, so no second domain exists inside the block.
  assign o_sys_clk_out      = i_sys_clk;

  // ---------------------------------------------------------------------
  // Shared pins
  // ---------------------------------------------------------------------
  logic [mpbc_pkg::SHARE_N-1:0] alt_out, alt_sel;
  assign alt_out = {cs_n_r[5:4], addr_r[25:22]};
  assign alt_sel = {{2{boot_cs_r}}, {mpbc_pkg::SHARE_ADDR_N{boot_addr_r}}};

  for (genvar g = 0; g < mpbc_pkg::SHARE_N; g++) begin : g_share
    mpbc_pin_share u_share (
      .i_alt_sel (alt_sel[g]),
      .i_alt_out (alt_out[g]),
      .i_alt_oe  (ctl_oe_r),
      .i_gp_out  (i_gpio_out[g]),
      .i_gp_oe   (i_gpio_oe[g]),
      .o_gp_in   (o_gpio_in[g]),
      .i_pin_in  (i_gp_io[g]),
      .o_pin_out (o_gp_io[g]),
      .o_pin_oe  (o_gp_io_oe[g])
    );
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  dir_read_a: assert property (in_acc && !wr_r |-> !o_xcvr_dir_n)
    else $error("Direction not low during read.");
  oe_ext_a: assert property (take && !i_req_write |=>
    o_xcvr_oe_n[0] == $past(i_req_sdram))
    else $error("Device read enable wrong.");
  oe_split_a: assert property (take |=> o_xcvr_oe_n[1] ==
    !($past(i_req_sdram) && !$past(i_req_write)))
    else $error("SDRAM read enable wrong.");
  cs_single_a: assert property ($countones(~cs_n_r) <= 1)
    else $error("More than one chip select asserted.");
  grant_resp_a: assert property (
    in_idle && !i_ext_bus_req_n && boot_done_r
    |=> !o_ext_bus_gnt_n && !o_mem_addr_oe && !o_ctl_oe)
    else $error("Grant or float missing after request.");
  grant_hold_a: assert property ($rose(o_ext_bus_gnt_n)
    |-> $past(i_ext_bus_req_n, 1))
    else $error("Grant removed while request held.");
  wait_ext_a: assert property (in_acc && !i_cfg_ack_mode &&
    !i_wait_or_ack_n |=> in_acc && !o_rsp_valid)
    else $error("Wait did not lengthen the cycle.");
  ack_done_a: assert property (in_acc && i_cfg_ack_mode &&
    !i_wait_or_ack_n |=> o_rsp_valid ##1 in_idle)
    else $error("Acknowledge did not complete access.");
  idle_rest_a: assert property (in_idle |-> &cs_n_r && o_xcvr_dir_n
    && &o_xcvr_oe_n)
    else $error("Strobe active while idle.");
  rst_pulse_a: assert property ($fell(rst_drv_r)
    |-> $past(rst_cnt_r) == 8'(RST_CYC - 1))
    else $error("Reset pin released at wrong count.");
  mask_pin_a: assert property (i_cfg_sodimm |->
    o_mem_addr[mpbc_pkg::MASK_MSB:mpbc_pkg::MASK_LSB] == mask_r)
    else $error("Mask enables not on address pins.");

  rd_cov_c: cover property (take && !i_req_write ##[1:20] o_rsp_valid);
  wr_cov_c: cover property (take && i_req_write ##[1:20] o_rsp_valid);
  gnt_cov_c: cover property ($fell(o_ext_bus_gnt_n) ##[1:20]
    $rose(o_ext_bus_gnt_n));
  warm_cov_c: cover property (o_warm_rst_req);

endmodule
`default_nettype wire

//--- hw/mpbc_pkg.sv
/*
  Shared constants and types of the memory and peripheral bus control block.
  Assumes a single 40 MHz system clock; all counts derive from its period.
*/
package mpbc_pkg;

  // ---------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W       = 26;
  localparam int DATA_W       = 32;
  localparam int ADDR_PIN_W   = 22;
  localparam int CS_N         = 6;
  localparam int CS_IDX_W     = 3;
  localparam int CS_PIN_N     = 4;
  localparam int MASK_LSB     = 17;
  localparam int MASK_MSB     = 20;
  localparam int MASK_W       = 4;
  localparam int WAIT_W       = 4;

  // ---------------------------------------------------------------------
  // Shared pins: general-purpose I/O numbers of the alternate functions
  // ---------------------------------------------------------------------
  localparam int SHARE_N      = 6;
  localparam int SHARE_ADDR_N = 4;
  localparam int GP_ADDR_BASE = 27;
  localparam int GP_CS_BASE   = 16;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int RST_DRIVE_NS  = 1000;
  localparam int RST_DRIVE_CYC =
    (RST_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W     = 8;

  // ---------------------------------------------------------------------
  // Core clock multiple: boot code and resulting factor
  // ---------------------------------------------------------------------
  localparam logic [1:0] BOOT_MULT_X2 = 2'h0;
  localparam logic [1:0] BOOT_MULT_X3 = 2'h1;
  localparam logic [1:0] BOOT_MULT_X4 = 2'h2;
  localparam logic [2:0] MULT_X2      = 3'h2;
  localparam logic [2:0] MULT_X3      = 3'h3;
  localparam logic [2:0] MULT_X4      = 3'h4;

  // Bus sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ACC   = 4'b0010,
    ST_END   = 4'b0100,
    ST_GRANT = 4'b1000
  } mpbc_state_t;

endpackage

//--- hw/mpbc_pin_share.sv
/*
  One pin shared between general-purpose I/O and a bus alternate function.
  Assumes the selection is stable; the pin itself is resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none

module mpbc_pin_share (
  // Selection
  input  wire logic i_alt_sel,
  // Bus side
  input  wire logic i_alt_out,
  input  wire logic i_alt_oe,
  // General-purpose side
  input  wire logic i_gp_out,
  input  wire logic i_gp_oe,
  output logic      o_gp_in,
  // Pin side
  input  wire logic i_pin_in,
  output logic      o_pin_out,
  output logic      o_pin_oe
);

  // ---------------------------------------------------------------------
  // Pin steering
  // ---------------------------------------------------------------------
  // The general-purpose side always sees the pin, so software can read back
  // what the bus drives when the alternate role is active.
  assign o_pin_out = i_alt_sel ? i_alt_out : i_gp_out;
  assign o_pin_oe  = i_alt_sel ? i_alt_oe  : i_gp_oe;
  assign o_gp_in   = i_pin_in;

endmodule
`default_nettype wire

//--- sim/mpbc_mem_model.sv
/*
  Far-side model: memory or peripheral answering reads, with wait or ack.
  Assumes the bus control block's strobes and one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module mpbc_mem_model (
  // Clock
  input  wire logic        i_clk,
  // Strobes and setup
  input  wire logic [1:0]  i_oe_n,
  input  wire logic        i_data_oe,
  input  wire logic        i_ack_mode,
  input  wire logic [3:0]  i_dly,
  input  wire logic [31:0] i_word,
  // Answers
  output logic [31:0]      o_data,
  output logic             o_wait_n
);
  logic [31:0] last_r = 32'h0000_0000;
  logic [3:0]  cnt_r;
  wire         rd  = (i_oe_n != 2'b11);
  wire         act = rd || i_data_oe;

  // A released bus shows a changing pattern, so stale data cannot pass.
  assign o_data = rd ? i_word : ~last_r;
  // Slow devices stretch or acknowledge late; line rests on its pull-up.
  assign o_wait_n = !act ? 1'b1 :
                    i_ack_mode ? (cnt_r < i_dly) : (cnt_r >= i_dly);

  // Cycle count within the current access.
  always @(posedge i_clk) begin
    last_r <= o_data;
    cnt_r  <= act ? cnt_r + 4'h1 : 4'h0;
  end
endmodule

`default_nettype wire

//--- sim/memory_peripheral_bus_control_test.sv
/*
  Self-checking bench of the bus control block with a far-side model.
  Assumes a 40 MHz clock and a short reset-pin drive of 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module memory_peripheral_bus_control_test;
  logic clk = 0, nrst = 0, valid = 0, wr = 0, sd = 0, ack = 0;
  logic sodimm = 0, req_n = 1, ext_warm = 0, strap = 0;
  logic [2:0] cs = 0, mult;
  logic [25:0] addr = 0;
  logic [31:0] wdata = 0, word = 0, rdata, mdo, mdm, mdi;
  logic [3:0] mask = 0, dly = 0, wcyc = 0, sel_n;
  logic [5:0] gout = 6'h2A, goe = 6'h0F, gp_o, gp_oe, gp_in, gpin;
  logic [21:0] mem_addr;
  logic [1:0] oe_n;
  logic ready, rvalid, clko, mem_addr_oe, mdoe, dir_n, ctl_oe, wait_n;
  logic gnt_n, wr_oe, wr_req, wpin;
  int err_count = 0, checked = 0, lat, n;

  // Pins resolved from every party's enable; reset pin has a pull-up.
  assign mdi  = mdoe ? mdo : mdm;
  assign wpin = (wr_oe || ext_warm) ? 1'b0 : 1'b1;
  assign gpin = (gp_o & gp_oe) | (6'h15 & ~gp_oe);
  always #12.5 clk = ~clk;

  mpbc_bus_ctrl #(.RST_CYC(4)) mpbc_bus_ctrl_i (
    .i_sys_clk(clk), .i_nrst(nrst), .i_req_valid(valid),
    .o_req_ready(ready), .i_req_write(wr), .i_req_sdram(sd),
    .i_req_cs(cs), .i_req_addr(addr), .i_req_wdata(wdata),
    .i_req_mask(mask), .o_rsp_valid(rvalid), .o_rsp_rdata(rdata),
    .i_cfg_ack_mode(ack), .i_cfg_sodimm(sodimm), .i_cfg_wait_cyc(wcyc),
    .i_boot_addr_hi(strap), .i_boot_cs_hi(strap),
    .i_boot_mult(mpbc_pkg::BOOT_MULT_X4), .o_core_mult(mult),
    .o_sys_clk_out(clko), .o_mem_addr(mem_addr), .o_mem_addr_oe(mem_addr_oe),
    .i_mem_data(mdi), .o_mem_data(mdo), .o_mem_data_oe(mdoe),
    .o_xcvr_dir_n(dir_n), .o_xcvr_oe_n(oe_n), .o_dev_sel_n(sel_n),
    .o_ctl_oe(ctl_oe), .i_wait_or_ack_n(wait_n), .i_ext_bus_req_n(req_n),
    .o_ext_bus_gnt_n(gnt_n), .i_warm_rst_io_n(wpin),
    .o_warm_rst_io_n_oe(wr_oe), .o_warm_rst_req(wr_req),
    .i_gp_io(gpin), .o_gp_io(gp_o), .o_gp_io_oe(gp_oe),
    .i_gpio_out(gout), .i_gpio_oe(goe), .o_gpio_in(gp_in));

  mpbc_mem_model mpbc_mem_model_i (
    .i_clk(clk), .i_oe_n(oe_n), .i_data_oe(mdoe), .i_ack_mode(ack),
    .i_dly(dly), .i_word(word), .o_data(mdm), .o_wait_n(wait_n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Present a request, hold it until taken; returns in the first cycle.
  task automatic start(input logic w, s, input logic [2:0] c,
                       input logic [25:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w; sd <= s; cs <= c; addr <= a; wdata <= d; valid <= 1'b1;
    #1;
    for (n = 0; n < 60 && ready !== 1'b1; n++) begin @(posedge clk); #1; end
    if (n == 60) begin err_count++; print_verdict(); end
    @(posedge clk);
    valid <= 1'b0;
    #1;
  endtask

  // Wait for the end of the access, counting cycles from the take.
  task automatic finish;
    for (lat = 1; lat < 60 && rvalid !== 1'b1; lat++) begin
      @(posedge clk);
      #1;
    end
    if (lat == 60) begin err_count++; print_verdict(); end
  endtask

  task automatic s_reads;
    for (int c = 0; c < 7; c++) begin
      word <= 32'h1234_5670 + c;
      start(1'b0, 1'b0, c[2:0], 26'h2AB_CDEF, 32'h0000_0000);
      chk(dir_n, 1'b0);
      chk(oe_n, 2'b10);
      chk(sel_n, c < 4 ? 4'(~(4'h1 << c)) : 4'hF);
      chk(mem_addr, 22'h2B_CDEF);
      finish();
      chk(rdata, 32'h1234_5670 + c);
      chk(sel_n, 4'hF);
    end
    start(1'b0, 1'b1, 3'h0, 26'h000_0040, 32'h0000_0000);
    chk({oe_n, sel_n}, 6'h1F);
    finish();
  endtask

  task automatic s_write;
    sodimm <= 1'b1;
    mask <= 4'hA;
    start(1'b1, 1'b0, 3'h2, 26'h000_0000, 32'hCAFE_0123);
    chk({dir_n, oe_n, mdoe}, 4'hF);
    chk(mdo, 32'hCAFE_0123);
    chk(mem_addr[20:17], 4'hA);
    finish();
    sodimm <= 1'b0;
  endtask

  task automatic s_slow;
    dly <= 4'h3;
    start(1'b0, 1'b0, 3'h1, 26'h000_0100, 32'h0000_0000);
    finish();
    chk(lat > 3, 1'b1);
    ack <= 1'b1;
    start(1'b0, 1'b0, 3'h1, 26'h000_0104, 32'h0000_0000);
    chk(sel_n, 4'hD);
    finish();
    chk(lat > 3, 1'b1);
    ack <= 1'b0;
    dly <= 4'h0;
    // Base wait count alone stretches the cycle to two plus the count.
    wcyc <= 4'h3;
    start(1'b0, 1'b0, 3'h1, 26'h000_0108, 32'h0000_0000);
    finish();
    chk(lat, 5);
    wcyc <= 4'h0;
  endtask

  // Second cold reset with the straps set: shared pins take the bus role.
  task automatic s_alt;
    @(posedge clk);
    nrst <= 1'b0;
    strap <= 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    start(1'b0, 1'b0, 3'h4, 26'h3C0_0000, 32'h0000_0000);
    chk({gp_oe, gp_in}, 12'hFEF);
    finish();
    chk(sel_n, 4'hF);
  endtask

  task automatic s_grant;
    @(posedge clk);
    req_n <= 1'b0;
    for (n = 0; n < 10 && gnt_n !== 1'b0; n++) begin @(posedge clk); #1; end
    chk(gnt_n, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk({gnt_n, ctl_oe, mem_addr_oe, mdoe, ready}, 5'h0);
    req_n <= 1'b1;
    for (n = 0; n < 10 && gnt_n !== 1'b1; n++) begin @(posedge clk); #1; end
    chk({gnt_n, ctl_oe}, 2'h3);
  endtask

  task automatic s_warm;
    @(posedge clk);
    ext_warm <= 1'b1;
    for (n = 0; n < 5 && wr_req !== 1'b1; n++) begin @(posedge clk); #1; end
    chk({wr_req, wr_oe}, 2'h3);
    ext_warm <= 1'b0;
    for (n = 0; n < 20 && wr_oe !== 1'b0; n++) begin @(posedge clk); #1; end
    chk({wr_oe, wpin}, 2'h1);
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (10) @(posedge clk);
    #1;
    chk({wr_oe, gnt_n, dir_n, oe_n, sel_n}, 9'h1FF);
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk({wr_oe, ready}, 2'h2);
    chk({gp_oe, gp_in}, 12'h3DA);
    chk(mult, mpbc_pkg::MULT_X4);
    chk(clko, clk);
    s_reads();
    s_write();
    s_slow();
    s_grant();
    s_warm();
    s_alt();
    print_verdict();
  end
endmodule

`default_nettype wire
